// *** src/standby_and_slow_mode_control.sv ***
// halt and slow mode controller: run mode bits, halt entry, release and resume signalling
//
// Function
// - in cpu halt mode the CPU and watchdog stop; peripherals keep running.
// - halt modes keep memory, registers, status word and port latches unchanged.
// - on halt entry the program counter points two past the entry instruction.
// - software clears master enable, enables wake source, then writes halt request.
// - cpu halt release clears the halt request and restores the previous run mode.
// - reset pin low releases any halt; execution restarts in fast single clock run.
// - master enable low: enabled interrupt wakes, resumes inline, latch stays set.
// - master enable high: enabled interrupt wakes and starts its service routine.
// - watchdog interrupt just before entry is serviced and the halt is skipped.
// - time-base-only halt gates every peripheral clock except the time-base timer.
// - software stops peripherals, then writes the time-base halt request bit.
// - time-base halt release clears its request bit and restores the run mode.
// - time-base irq enable set at time-base halt entry sets the time-base latch.
// - time-base halt ends on falling edge of selected tap, irq enable irrelevant.
// - enable product zero: release resumes at the instruction after entry.
// - enable product one: release starts time-base interrupt processing.
// - release edge is asynchronous, so the halt may be shorter than a period.
// - slow switch: select low clock first, then clear the fast oscillator enable.
// - control register bits: fast oscillator 7, slow oscillator 6, clock select 5.
`timescale 1ns/1ps
`include "sbm_map.svh"

module standby_and_slow_mode_control
	import sbm_pkg::*;
(
	// clock and reset
	input  wire logic                   clk_i,
	input  wire logic                   srst_i,
	// external reset pin, active low, asynchronous
	input  wire logic                   ext_rst_n_i,
	// register port
	input  wire logic [`SBM_ADDR_W-1:0] addr_i,
	input  wire logic [`SBM_DATA_W-1:0] wdata_i,
	input  wire logic                   wr_i,
	input  wire logic                   rd_i,
	output logic      [`SBM_DATA_W-1:0] rdata_o,
	// cpu core
	input  wire logic [`SBM_PC_W-1:0]   instr_addr_i,
	input  wire logic                   master_irq_enable_i,
	output logic                        cpu_halt_o,
	output logic                        wdt_halt_o,
	output logic [`SBM_PC_W-1:0]        resume_pc_o,
	output logic                        resume_inline_o,
	output logic                        service_start_o,
	// interrupt controller
	input  wire logic                   wake_irq_i,
	input  wire logic                   wdt_irq_i,
	input  wire logic                   time_base_source_enable_i,
	output logic                        tb_latch_set_o,
	// time-base divider taps, asynchronous
	input  wire logic [`SBM_TB_TAPS-1:0] tb_taps_i,
	// clock generator
	output logic                        periph_clk_en_o,
	output logic                        fast_osc_enable_o,
	output logic                        slow_osc_enable_o,
	output logic                        sys_clock_select_o,
	output run_mode_t                   run_mode_o
);

	halt_state_t             state_reg;
	halt_state_t             state_next;
	logic                    fast_osc_reg;
	logic                    fast_osc_next;
	logic                    slow_osc_reg;
	logic                    slow_osc_next;
	logic                    clk_sel_reg;
	logic                    clk_sel_next;
	logic                    halt_req_reg;
	logic                    halt_req_next;
	logic                    tb_halt_req_reg;
	logic                    tb_halt_req_next;
	logic                    tb_irq_en_reg;
	logic [`SBM_TB_SEL_MSB:0] tb_sel_reg;
	logic [2:0]              saved_reg;
	logic [2:0]              saved_next;
	logic [`SBM_PC_W-1:0]    resume_pc_reg;
	logic [`SBM_DATA_W-1:0]  rdata_reg;
	logic                    cpu_halt_reg;
	logic                    periph_en_reg;
	logic                    inline_reg;
	logic                    inline_next;
	logic                    service_reg;
	logic                    service_next;
	logic                    tb_set_reg;
	logic                    tb_set_next;
	run_mode_t               mode_reg;
	run_mode_t               mode_next;

	// register decode
	wire logic wr_sys   = wr_i && (addr_i == `SBM_ADDR_SYSCTL_B);
	wire logic wr_tb    = wr_i && (addr_i == `SBM_ADDR_TB_CTL);
	wire logic in_run   = (state_reg == ST_RUN);
	wire logic req_halt = wr_sys && wdata_i[`SBM_BIT_HALT_REQ];
	wire logic req_tb   = wr_sys && wdata_i[`SBM_BIT_TB_HALT_REQ] && !wdata_i[`SBM_BIT_HALT_REQ];
	wire logic enter_cpu_halt = in_run && req_halt && !wdt_irq_i;
	wire logic enter_tb_halt  = in_run && req_tb && !wdt_irq_i;
	wire logic enter_any      = enter_cpu_halt || enter_tb_halt;

	// reset pin and time-base tap pass two flip-flops before use
	logic ext_rst_lvl;
	logic tap_fall;
	wire logic tap_sel = tb_taps_i[tb_sel_reg];

	pin_sync #(.RST_VAL(1'b1)) rst_pin_sync (
		.clk_i   (clk_i),
		.srst_i  (srst_i),
		.async_i (ext_rst_n_i),
		.level_o (ext_rst_lvl),
		.fall_o  ()
	);

	// the tap runs free of this clock, so the first edge after entry may come early
	pin_sync #(.RST_VAL(1'b0)) tap_sync (
		.clk_i   (clk_i),
		.srst_i  (srst_i),
		.async_i (tap_sel),
		.level_o (),
		.fall_o  (tap_fall)
	);

	wire logic pin_reset   = !ext_rst_lvl;
	wire logic cpu_release = (state_reg == ST_CPU_HALT) && wake_irq_i;
	wire logic tb_release  = (state_reg == ST_TB_HALT) && tap_fall;
	wire logic tb_product  = master_irq_enable_i && time_base_source_enable_i && tb_irq_en_reg;

	function automatic run_mode_t mode_of(input logic fast, input logic slow, input logic sel);
		if (sel)
			mode_of = fast ? SLOW_RUN_FAST_OSC_ON : SLOW_RUN_FAST_OSC_OFF;
		else
			mode_of = slow ? FAST_DUAL_CLOCK_RUN : FAST_SINGLE_CLOCK_RUN;
	endfunction : mode_of

	always_comb begin
		state_next       = state_reg;
		fast_osc_next    = fast_osc_reg;
		slow_osc_next    = slow_osc_reg;
		clk_sel_next     = clk_sel_reg;
		halt_req_next    = halt_req_reg;
		tb_halt_req_next = tb_halt_req_reg;
		saved_next       = saved_reg;
		inline_next      = 1'b0;
		service_next     = 1'b0;
		tb_set_next      = 1'b0;
		case (state_reg)
			ST_RUN: begin
				if (wr_sys) begin
					// oscillator and clock select follow bit writes directly
					fast_osc_next = wdata_i[`SBM_BIT_FAST_OSC];
					slow_osc_next = wdata_i[`SBM_BIT_SLOW_OSC];
					clk_sel_next  = wdata_i[`SBM_BIT_CLK_SEL];
				end
				if (enter_cpu_halt) begin
					state_next    = ST_CPU_HALT;
					halt_req_next = 1'b1;
				end else if (enter_tb_halt) begin
					state_next       = ST_TB_HALT;
					tb_halt_req_next = 1'b1;
					tb_set_next      = tb_irq_en_reg;
				end
				if (enter_any) begin
					saved_next = {wdata_i[`SBM_BIT_FAST_OSC], wdata_i[`SBM_BIT_SLOW_OSC],
						wdata_i[`SBM_BIT_CLK_SEL]};
				end
			end
			ST_CPU_HALT: begin
				if (cpu_release) begin
					state_next    = ST_RUN;
					halt_req_next = 1'b0;
					{fast_osc_next, slow_osc_next, clk_sel_next} = saved_reg;
					// the source latch is left alone; software clears it
					service_next  = master_irq_enable_i;
					inline_next   = !master_irq_enable_i;
				end
			end
			ST_TB_HALT: begin
				if (tb_release) begin
					state_next       = ST_RUN;
					tb_halt_req_next = 1'b0;
					{fast_osc_next, slow_osc_next, clk_sel_next} = saved_reg;
					service_next     = tb_product;
					inline_next      = !tb_product;
				end
			end
			default: begin
				state_next = ST_RUN;
			end
		endcase
		mode_next = mode_of(fast_osc_next, slow_osc_next, clk_sel_next);
	end

	always_ff @(posedge clk_i) begin
		if (srst_i || pin_reset) begin
			state_reg       <= ST_RUN;
			fast_osc_reg    <= 1'(`SBM_SYSCTL_RST >> `SBM_BIT_FAST_OSC);
			slow_osc_reg    <= 1'b0;
			clk_sel_reg     <= 1'b0;
			halt_req_reg    <= 1'b0;
			tb_halt_req_reg <= 1'b0;
			// the saved bits start as the reset run mode bits
			saved_reg       <= 3'(`SBM_SYSCTL_RST >> `SBM_BIT_CLK_SEL);
			mode_reg        <= FAST_SINGLE_CLOCK_RUN;
			cpu_halt_reg    <= 1'b0;
			periph_en_reg   <= 1'b1;
			inline_reg      <= 1'b0;
			service_reg     <= 1'b0;
			tb_set_reg      <= 1'b0;
		end else begin
			state_reg       <= state_next;
			fast_osc_reg    <= fast_osc_next;
			slow_osc_reg    <= slow_osc_next;
			clk_sel_reg     <= clk_sel_next;
			halt_req_reg    <= halt_req_next;
			tb_halt_req_reg <= tb_halt_req_next;
			saved_reg       <= saved_next;
			mode_reg        <= mode_next;
			// the stall freezes CPU state, port latches and memory strobes
			cpu_halt_reg    <= (state_next != ST_RUN);
			periph_en_reg   <= (state_next != ST_TB_HALT);
			inline_reg      <= inline_next;
			service_reg     <= service_next;
			tb_set_reg      <= tb_set_next;
		end
	end

	// time-base control and resume address
	always_ff @(posedge clk_i) begin
		if (srst_i || pin_reset) begin
			tb_irq_en_reg <= 1'b0;
			tb_sel_reg    <= '0;
			resume_pc_reg <= '0;
		end else begin
			if (wr_tb && in_run) begin
				tb_irq_en_reg <= wdata_i[`SBM_BIT_TB_IRQ_EN];
				tb_sel_reg    <= wdata_i[`SBM_TB_SEL_MSB:0];
			end
			if (enter_any) begin
				resume_pc_reg <= instr_addr_i + `SBM_PC_STEP;
			end
		end
	end

	// read data, one cycle after the strobe
	wire logic [`SBM_DATA_W-1:0] sys_rd = {fast_osc_reg, slow_osc_reg, clk_sel_reg,
		halt_req_reg, 1'b0, tb_halt_req_reg, 2'b00};
	wire logic [`SBM_DATA_W-1:0] tb_rd  = {4'h0, tb_irq_en_reg, tb_sel_reg};
	wire logic [`SBM_DATA_W-1:0] st_rd  = {2'b00, !periph_en_reg, cpu_halt_reg,
		2'b00, mode_reg};
	wire logic [`SBM_DATA_W-1:0] rd_mux =
		(addr_i == `SBM_ADDR_SYSCTL_B) ? sys_rd :
		(addr_i == `SBM_ADDR_TB_CTL)   ? tb_rd :
		(addr_i == `SBM_ADDR_STATUS)   ? st_rd :
		(addr_i == `SBM_ADDR_PC_LO)    ? resume_pc_reg[7:0] :
		(addr_i == `SBM_ADDR_PC_HI)    ? resume_pc_reg[15:8] : 8'h00;

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			rdata_reg <= 8'h00;
		end else begin
			rdata_reg <= rd_i ? rd_mux : 8'h00;
		end
	end

	assign rdata_o            = rdata_reg;
	assign cpu_halt_o         = cpu_halt_reg;
	assign wdt_halt_o         = cpu_halt_reg;
	assign resume_pc_o        = resume_pc_reg;
	assign resume_inline_o    = inline_reg;
	assign service_start_o    = service_reg;
	assign tb_latch_set_o     = tb_set_reg;
	assign periph_clk_en_o    = periph_en_reg;
	assign fast_osc_enable_o  = fast_osc_reg;
	assign slow_osc_enable_o  = slow_osc_reg;
	assign sys_clock_select_o = clk_sel_reg;
	assign run_mode_o         = mode_reg;

	chk_halt_entry: assert property (
		@(posedge clk_i) disable iff (srst_i || pin_reset)
		enter_cpu_halt |=> cpu_halt_o && wdt_halt_o && halt_req_reg && periph_clk_en_o)
		else $error("cpu halt not entered after request");

	chk_wdt_abort: assert property (
		@(posedge clk_i) disable iff (srst_i || pin_reset)
		in_run && (req_halt || req_tb) && wdt_irq_i |=> !cpu_halt_o && state_reg == ST_RUN)
		else $error("halt entered despite watchdog interrupt");

	chk_halt_clear: assert property (
		@(posedge clk_i) disable iff (srst_i || pin_reset)
		cpu_release |=> !halt_req_reg && !cpu_halt_o)
		else $error("halt request not cleared on release");

	chk_wake_service: assert property (
		@(posedge clk_i) disable iff (srst_i || pin_reset)
		cpu_release && master_irq_enable_i |=> service_start_o ##1 !service_start_o)
		else $error("service not started once on wake");

	chk_wake_inline: assert property (
		@(posedge clk_i) disable iff (srst_i || pin_reset)
		cpu_release && !master_irq_enable_i |=> resume_inline_o && !service_start_o)
		else $error("inline resume missing on wake");

	chk_tb_gate: assert property (
		@(posedge clk_i) disable iff (srst_i || pin_reset)
		enter_tb_halt |=> !periph_clk_en_o && tb_halt_req_reg && cpu_halt_o)
		else $error("peripheral clocks not gated in time-base halt");

	chk_tb_latch: assert property (
		@(posedge clk_i) disable iff (srst_i || pin_reset)
		enter_tb_halt |=> tb_latch_set_o == $past(tb_irq_en_reg))
		else $error("time-base latch set wrong at entry");

	chk_tb_release: assert property (
		@(posedge clk_i) disable iff (srst_i || pin_reset)
		tb_release |=> !tb_halt_req_reg && periph_clk_en_o
			&& service_start_o == $past(tb_product) && resume_inline_o == !$past(tb_product))
		else $error("time-base release outcome wrong");

	chk_resume_pc: assert property (
		@(posedge clk_i) disable iff (srst_i || pin_reset)
		enter_any |=> resume_pc_o == $past(instr_addr_i) + `SBM_PC_STEP)
		else $error("resume address not two past entry");

	chk_mode_restore: assert property (
		@(posedge clk_i) disable iff (srst_i || pin_reset)
		cpu_release || tb_release |=>
			{fast_osc_enable_o, slow_osc_enable_o, sys_clock_select_o} == saved_reg
			&& run_mode_o == mode_of(saved_reg[2], saved_reg[1], saved_reg[0]))
		else $error("run mode not restored after halt");

	chk_halt_hold: assert property (
		@(posedge clk_i) disable iff (srst_i || pin_reset)
		cpu_halt_o && state_next != ST_RUN |=> $stable(run_mode_o) && $stable(resume_pc_o))
		else $error("state changed during halt");

	chk_pin_reset: assert property (
		@(posedge clk_i) disable iff (srst_i)
		pin_reset |=> !cpu_halt_o && run_mode_o == FAST_SINGLE_CLOCK_RUN)
		else $error("reset pin did not release halt");

endmodule : standby_and_slow_mode_control

// *** src/sbm_map.svh ***
// register offsets, field positions, reset values and widths of the standby controller
`ifndef SBM_MAP_SVH
`define SBM_MAP_SVH

`define SBM_ADDR_W          4
`define SBM_DATA_W          8
`define SBM_PC_W            16

`define SBM_ADDR_SYSCTL_B   4'h0
`define SBM_ADDR_TB_CTL     4'h1
`define SBM_ADDR_STATUS     4'h2
`define SBM_ADDR_PC_LO      4'h3
`define SBM_ADDR_PC_HI      4'h4

`define SBM_BIT_FAST_OSC    7
`define SBM_BIT_SLOW_OSC    6
`define SBM_BIT_CLK_SEL     5
`define SBM_BIT_HALT_REQ    4
`define SBM_BIT_TB_HALT_REQ 2

`define SBM_BIT_TB_IRQ_EN   3
`define SBM_TB_SEL_MSB      2
`define SBM_TB_TAPS         8

`define SBM_SYSCTL_RST      8'h80
`define SBM_TB_CTL_RST      8'h00
`define SBM_PC_STEP         16'h0002

`endif

// *** src/sbm_pkg.sv ***
// types shared by the standby and slow mode controller
package sbm_pkg;

	typedef enum logic [1:0] {
		FAST_SINGLE_CLOCK_RUN,
		FAST_DUAL_CLOCK_RUN,
		SLOW_RUN_FAST_OSC_ON,
		SLOW_RUN_FAST_OSC_OFF
	} run_mode_t;

	typedef enum {
		ST_RUN,
		ST_CPU_HALT,
		ST_TB_HALT
	} halt_state_t;

endpackage : sbm_pkg

// *** src/pin_sync.sv ***
// two flip-flop synchroniser with a falling edge pulse on the settled side
`timescale 1ns/1ps
module pin_sync #(
	parameter logic RST_VAL = 1'b1
) (
	// clock and reset
	input  wire logic clk_i,
	input  wire logic srst_i,
	// asynchronous input
	input  wire logic async_i,
	// synchronised outputs
	output logic      level_o,
	output logic      fall_o
);

	logic meta_reg;
	logic sync_reg;
	logic prev_reg;

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			meta_reg <= RST_VAL;
			sync_reg <= RST_VAL;
			prev_reg <= RST_VAL;
		end else begin
			meta_reg <= async_i;
			sync_reg <= meta_reg;
			prev_reg <= sync_reg;
		end
	end

	assign level_o = sync_reg;
	assign fall_o  = prev_reg & ~sync_reg;

endmodule : pin_sync

// *** testbench/core_irq_model.sv ***
// interrupt controller and time-base divider as seen from the standby controller
`timescale 1ns/1ps
`include "sbm_map.svh"
module core_irq_model (
	// clock and reset
	input  wire logic                    clk_i,
	input  wire logic                    srst_i,
	// wake request from the bench, resume pulses from the block
	input  wire logic                    raise_i,
	input  wire logic                    resume_inline_i,
	input  wire logic                    service_start_i,
	// towards the block
	output logic                         wake_irq_o,
	output logic [`SBM_TB_TAPS-1:0]      tb_taps_o
);
	logic                    pend_reg;
	logic [`SBM_TB_TAPS-1:0] div_reg = 8'h00;

	// divider runs on its own unrelated clock, so release edges are asynchronous
	always #7.3 div_reg = div_reg + 8'h01;
	assign tb_taps_o = div_reg;
	assign wake_irq_o = pend_reg;

	// latch stays set through the wake, cleared by the resume inline or service start pulse
	always_ff @(posedge clk_i) begin
		if (srst_i)
			pend_reg <= 1'b0;
		else if (raise_i)
			pend_reg <= 1'b1;
		else if (resume_inline_i || service_start_i)
			pend_reg <= 1'b0;
	end
endmodule : core_irq_model

// *** testbench/test_standby_and_slow_mode_control.sv ***
// self-checking bench for the halt and slow mode controller
`timescale 1ns/1ps
`include "sbm_map.svh"
module test_standby_and_slow_mode_control
	import sbm_pkg::*;
;
	typedef struct {
		logic [7:0] ctl;
		logic [7:0] tbc;
		logic       mie;
		logic       src;
		logic       svc;
		logic       latch;
	} row_t;

	logic                    clk_i = 1'b0;
	logic                    srst_i = 1'b1;
	logic                    ext_rst_n_i = 1'b1;
	logic [3:0]              addr_i = 4'h0;
	logic [7:0]              wdata_i = 8'h00;
	logic                    wr_i = 1'b0;
	logic                    rd_i = 1'b0;
	logic [7:0]              rdata_o;
	logic [15:0]             instr_addr_i = 16'h0000;
	logic                    mie_i = 1'b0;
	logic                    cpu_halt_o, wdt_halt_o, resume_inline_o, service_start_o;
	logic [15:0]             resume_pc_o;
	logic                    wake_irq, raise = 1'b0, wdt_irq_i = 1'b0, src_en_i = 1'b0;
	logic                    tb_latch_set_o, periph_clk_en_o, fast_o, slow_o, sel_o;
	logic [7:0]              tb_taps;
	run_mode_t               run_mode_o;
	int                      bad_count = 0, comparisons = 0;
	int                      inline_n = 0, svc_n = 0, latch_n = 0;

	always #2.5 clk_i = ~clk_i;

	standby_and_slow_mode_control i_dut (.clk_i(clk_i), .srst_i(srst_i),
		.ext_rst_n_i(ext_rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
		.rd_i(rd_i), .rdata_o(rdata_o), .instr_addr_i(instr_addr_i),
		.master_irq_enable_i(mie_i), .cpu_halt_o(cpu_halt_o), .wdt_halt_o(wdt_halt_o),
		.resume_pc_o(resume_pc_o), .resume_inline_o(resume_inline_o),
		.service_start_o(service_start_o), .wake_irq_i(wake_irq), .wdt_irq_i(wdt_irq_i),
		.time_base_source_enable_i(src_en_i), .tb_latch_set_o(tb_latch_set_o),
		.tb_taps_i(tb_taps), .periph_clk_en_o(periph_clk_en_o), .fast_osc_enable_o(fast_o),
		.slow_osc_enable_o(slow_o), .sys_clock_select_o(sel_o), .run_mode_o(run_mode_o));

	core_irq_model i_irq (.clk_i(clk_i), .srst_i(srst_i), .raise_i(raise),
		.resume_inline_i(resume_inline_o), .service_start_i(service_start_o),
		.wake_irq_o(wake_irq), .tb_taps_o(tb_taps));

	always @(posedge clk_i) begin
		inline_n <= inline_n + int'(resume_inline_o === 1'b1);
		svc_n <= svc_n + int'(service_start_o === 1'b1);
		latch_n <= latch_n + int'(tb_latch_set_o === 1'b1);
	end

	task automatic conclude();
		$display("comparisons %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : conclude

	task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
		comparisons++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] %0t %s got %h want %h", $time, what, got, exp);
		end
	endtask : check

	task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge clk_i);
		wr_i <= 1'b0;
		#1;
	endtask : wr_reg

	task automatic rd_reg(input logic [3:0] a, input logic [7:0] exp, input string what);
		@(posedge clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1;
		check(16'(rdata_o), 16'(exp), what);
	endtask : rd_reg

	task automatic wait_run();
		int n;
		n = 0;
		while (cpu_halt_o !== 1'b0 && n < 600) begin
			@(posedge clk_i);
			#1;
			n++;
		end
		if (n >= 600) begin
			bad_count++;
			$display("[ERR] %0t halt never released", $time);
			conclude();
		end
	endtask : wait_run

	// the divider runs free, so every wait on a tap is bounded
	task automatic wait_tap(input logic v);
		int n;
		n = 0;
		while (tb_taps[7] !== v && n < 500) begin
			@(posedge clk_i);
			n++;
		end
		if (n >= 500) begin
			bad_count++;
			$display("[ERR] %0t time-base tap never toggled", $time);
			conclude();
		end
	endtask : wait_tap

	function automatic run_mode_t mode_of(input logic [7:0] c);
		if (!c[5])
			return c[6] ? FAST_DUAL_CLOCK_RUN : FAST_SINGLE_CLOCK_RUN;
		return c[7] ? SLOW_RUN_FAST_OSC_ON : SLOW_RUN_FAST_OSC_OFF;
	endfunction : mode_of

	// tap 7 is selected so that the release lands well after the status reads
	row_t rows [5] = '{
		'{8'h90, 8'h07, 1'b0, 1'b0, 1'b0, 1'b0},
		'{8'hD0, 8'h07, 1'b1, 1'b0, 1'b1, 1'b0},
		'{8'hE4, 8'h0F, 1'b1, 1'b1, 1'b1, 1'b1},
		'{8'h64, 8'h0F, 1'b0, 1'b1, 1'b0, 1'b1},
		'{8'hC4, 8'h07, 1'b1, 1'b1, 1'b0, 1'b0}};

	initial begin
		row_t       r;
		logic       tb;
		logic [15:0] pc;
		int         n0, s0, l0;
		repeat (5) @(posedge clk_i);
		srst_i <= 1'b0;
		rd_reg(`SBM_ADDR_SYSCTL_B, 8'h80, "control reset");
		rd_reg(`SBM_ADDR_TB_CTL, 8'h00, "tb ctl reset");
		rd_reg(4'hF, 8'h00, "unmapped");
		check(16'(run_mode_o), 16'(FAST_SINGLE_CLOCK_RUN), "mode reset");
		$display("reset test done");
		for (int i = 0; i < 5; i++) begin
			r = rows[i];
			tb = r.ctl[2];
			pc = 16'h1230 + 16'(i * 256);
			wr_reg(`SBM_ADDR_TB_CTL, r.tbc);
			// run mode bits first, halt request next: never both halt bits at once
			wr_reg(`SBM_ADDR_SYSCTL_B, r.ctl & 8'hE0);
			if (tb) begin
				wait_tap(1'b0);
				wait_tap(1'b1);
			end
			@(posedge clk_i);
			mie_i <= r.mie & tb;
			src_en_i <= r.src;
			instr_addr_i <= pc;
			n0 = inline_n;
			s0 = svc_n;
			l0 = latch_n;
			wr_reg(`SBM_ADDR_SYSCTL_B, r.ctl);
			check(16'(cpu_halt_o), 16'h0001, "halted");
			check(16'(wdt_halt_o), 16'h0001, "watchdog halted");
			check(resume_pc_o, pc + 16'h0002, "resume pc");
			check(16'(periph_clk_en_o), 16'(!tb), "peripheral clock");
			rd_reg(`SBM_ADDR_STATUS, {2'b00, tb, 1'b1, 2'b00, mode_of(r.ctl)}, "status");
			rd_reg(`SBM_ADDR_PC_LO, 8'(pc + 16'h0002), "pc low");
			rd_reg(`SBM_ADDR_PC_HI, 8'((pc + 16'h0002) >> 8), "pc high");
			wr_reg(`SBM_ADDR_SYSCTL_B, 8'h00);
			if (!tb) begin
				@(posedge clk_i);
				mie_i <= r.mie;
				raise <= 1'b1;
				@(posedge clk_i);
				raise <= 1'b0;
			end
			wait_run();
			if (tb)
				check(16'(tb_taps[7]), 16'h0000, "released on falling tap");
			repeat (2) @(posedge clk_i);
			#1;
			check(16'(svc_n - s0), 16'(r.svc), "service start");
			check(16'(inline_n - n0), 16'(!r.svc), "inline resume");
			check(16'(latch_n - l0), 16'(r.latch), "time-base latch");
			rd_reg(`SBM_ADDR_SYSCTL_B, r.ctl & 8'hE0, "control after wake");
			check(16'(run_mode_o), 16'(mode_of(r.ctl)), "mode restored");
			check(16'({fast_o, slow_o, sel_o}), 16'(r.ctl[7:5]), "osc bits");
			$display("row %0d done", i);
		end
		@(posedge clk_i);
		mie_i <= 1'b0;
		wdt_irq_i <= 1'b1;
		wr_reg(`SBM_ADDR_SYSCTL_B, 8'h90);
		check(16'(cpu_halt_o), 16'h0000, "watchdog abort");
		rd_reg(`SBM_ADDR_SYSCTL_B, 8'h80, "abort bits");
		wdt_irq_i <= 1'b0;
		$display("watchdog test done");
		wr_reg(`SBM_ADDR_SYSCTL_B, 8'hF0);
		check(16'(cpu_halt_o), 16'h0001, "halt before pin");
		@(posedge clk_i);
		ext_rst_n_i <= 1'b0;
		repeat (5) @(posedge clk_i);
		ext_rst_n_i <= 1'b1;
		repeat (4) @(posedge clk_i);
		#1;
		check(16'(cpu_halt_o), 16'h0000, "pin release");
		check(16'(run_mode_o), 16'(FAST_SINGLE_CLOCK_RUN), "pin mode");
		rd_reg(`SBM_ADDR_SYSCTL_B, 8'h80, "pin control");
		$display("reset pin test done");
		conclude();
	end
endmodule : test_standby_and_slow_mode_control
